// ---- hw/phy_port_config_status_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module phy_port_config_status_regs
  import phy_port_regs_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output var  logic [DATA_W-1:0] reg_rdata,
  output var  logic              reg_rvalid,
  input  wire port_state_t       port_state,
  input  wire fault_evt_t        fault_evt,
  input  wire logic              fault_src_read,
  output var  port_ctrl_t        port_ctrl
);

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  logic [DATA_W-1:0] cfg_r;
  logic              cfg_hit;

  always_comb begin
    if (reg_addr == CFG_ADDR) begin
      cfg_hit = 1'b1;
    end else begin
      cfg_hit = 1'b0;
    end
  end

  // Reserved bits are stored as written; software keeps them zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_r <= CFG_RESET;
    end else if (reg_wr && cfg_hit) begin
      cfg_r <= reg_wdata;
    end
  end

  // ****************************************************************
  // Summary error flag
  // ****************************************************************
  logic err_r;
  logic fault_any;

  assign fault_any = fault_evt.remote_fault | fault_evt.jabber | fault_evt.pd_fault;

  // A fault in the same cycle as the clearing read wins, so no event is lost
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      err_r <= 1'b0;
    end else if (fault_any) begin
      err_r <= 1'b1;
    end else if (fault_src_read) begin
      err_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Status word
  // ****************************************************************
  logic [DATA_W-1:0] stat_word;
  logic              link_eff;

  assign link_eff = port_state.link_raw | cfg_r[CFG_FORCE_LINK];

  // Polarity is meaningless at 100 Mbps, so it is masked there
  always_comb begin
    stat_word                = STAT_RESET;
    stat_word[STAT_SPEED100] = port_state.speed100;
    stat_word[STAT_TX_ACT]   = port_state.tx_active;
    stat_word[STAT_RX_ACT]   = port_state.rx_active;
    stat_word[STAT_COLL]     = port_state.collision;
    stat_word[STAT_LINK]     = link_eff;
    stat_word[STAT_DUPLEX]   = port_state.full_duplex;
    stat_word[STAT_AN_MODE]  = port_state.an_enabled;
    stat_word[STAT_AN_DONE]  = port_state.an_complete;
    stat_word[STAT_POLARITY] = port_state.polarity_rev & ~port_state.speed100;
    stat_word[STAT_PAUSE]    = port_state.pause_capable;
    stat_word[STAT_ERROR]    = err_r;
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Writes to the status address fall through; there is nothing to store
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= READ_UNMAPPED;
    end else if (reg_rd) begin
      if (cfg_hit) begin
        reg_rdata <= cfg_r;
      end else if (reg_addr == STAT_ADDR) begin
        reg_rdata <= stat_word;
      end else begin
        reg_rdata <= READ_UNMAPPED;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // ****************************************************************
  // Datapath controls
  // ****************************************************************
  logic ten_mode;
  assign ten_mode = ~port_state.speed100;

  always_comb begin
    port_ctrl.link_pass             = cfg_r[CFG_FORCE_LINK];
    port_ctrl.tx_disable            = cfg_r[CFG_TX_DISABLE];
    port_ctrl.scr_bypass            = cfg_r[CFG_SCR_BYPASS] & port_state.speed100;
    port_ctrl.jabber_off            = cfg_r[CFG_JABBER_OFF] & ten_mode;
    port_ctrl.heartbeat_test        = cfg_r[CFG_HEARTBEAT] & ten_mode;
    port_ctrl.twisted_pair_echo_off = cfg_r[CFG_ECHO_OFF] & ten_mode
                                      & ~port_state.full_duplex;
    port_ctrl.carrier_extend_select = cfg_r[CFG_CRS_EXTEND] & ten_mode;
    port_ctrl.preamble_deliver      = cfg_r[CFG_PRE_DELIVER]
                                      | port_state.speed100;
    port_ctrl.alt_next_page_enable  = cfg_r[CFG_ALT_NP];
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Status bits 15, 6 and 2:0 always read zero
  localparam logic [DATA_W-1:0] STAT_RSVD_MASK = 16'h8047;

  sequence cfg_write_s;
    reg_wr && cfg_hit;
  endsequence

  sequence cfg_read_s;
    reg_rd && cfg_hit && !reg_wr;
  endsequence

  sequence fault_s;
    fault_any;
  endsequence

  sequence cfg_gap_s;
    !reg_wr && !reg_rd;
  endsequence

  cfg_writeback_a: assert property (
    cfg_write_s ##1 cfg_gap_s ##1 cfg_read_s |=> reg_rdata == $past(reg_wdata, 3))
    else $error("configuration readback differs from write");

  cfg_read_a: assert property (cfg_read_s |=> reg_rvalid && reg_rdata == $past(cfg_r))
    else $error("configuration read returned wrong data");

  force_link_a: assert property (cfg_r[CFG_FORCE_LINK] |-> port_ctrl.link_pass
                                 && stat_word[STAT_LINK])
    else $error("forced link not passing");

  link_follow_a: assert property (!cfg_r[CFG_FORCE_LINK] |->
                                  stat_word[STAT_LINK] == port_state.link_raw)
    else $error("link status not following link");

  tx_disable_a: assert property (port_ctrl.tx_disable == cfg_r[CFG_TX_DISABLE])
    else $error("transmitter not disabled");

  scr_bypass_a: assert property (port_ctrl.scr_bypass |->
                                 port_state.speed100 && cfg_r[CFG_SCR_BYPASS])
    else $error("scrambler bypass outside 100BASE-TX");

  ten_ctrl_a: assert property (ten_mode |->
                               port_ctrl.jabber_off == cfg_r[CFG_JABBER_OFF]
                               && port_ctrl.heartbeat_test == cfg_r[CFG_HEARTBEAT]
                               && port_ctrl.carrier_extend_select == cfg_r[CFG_CRS_EXTEND])
    else $error("10BASE-T controls not following configuration");

  echo_off_a: assert property (port_ctrl.twisted_pair_echo_off |->
                               ten_mode && !port_state.full_duplex)
    else $error("echo disable outside 10BASE-T half duplex");

  preamble_sel_a: assert property (port_ctrl.preamble_deliver ==
                                   (cfg_r[CFG_PRE_DELIVER] || port_state.speed100))
    else $error("preamble delivery wrong");

  alt_np_a: assert property (port_ctrl.alt_next_page_enable == cfg_r[CFG_ALT_NP])
    else $error("next-page enable not following configuration");

  err_set_a: assert property (fault_s |=> err_r)
    else $error("error flag missed a fault");

  err_hold_a: assert property (err_r && !fault_src_read |=> err_r)
    else $error("error flag cleared without source read");

  err_clear_a: assert property (err_r && fault_src_read && !fault_any |=> !err_r)
    else $error("error flag not cleared by source read");

  stat_read_a: assert property (reg_rd && !cfg_hit && reg_addr == STAT_ADDR |=>
                                reg_rvalid && (reg_rdata & STAT_RSVD_MASK) == '0
                                && reg_rdata[STAT_SPEED100] == $past(port_state.speed100)
                                && reg_rdata[STAT_ERROR] == $past(err_r))
    else $error("status read wrong");

  stat_fields_a: assert property (stat_word[STAT_COLL] == port_state.collision
                                  && stat_word[STAT_DUPLEX] == port_state.full_duplex
                                  && stat_word[STAT_AN_DONE] == port_state.an_complete
                                  && stat_word[STAT_PAUSE] == port_state.pause_capable
                                  && stat_word[STAT_TX_ACT] == port_state.tx_active)
    else $error("status field mismatch");

  polarity_mask_a: assert property (port_state.speed100 |-> !stat_word[STAT_POLARITY])
    else $error("polarity reported at 100 Mbps");

  stat_nowrite_a: assert property (reg_wr && reg_addr == STAT_ADDR |=> $stable(cfg_r))
    else $error("status write changed configuration");

  // The default disable would mask the reset itself, so it is lifted here
  cfg_reset_a: assert property (disable iff (1'b0) !rst_n |=>
                                cfg_r == CFG_RESET && !err_r && !reg_rvalid)
    else $error("reset values not loaded");

  cfg_write_a: assert property (cfg_write_s |=> cfg_r == $past(reg_wdata))
    else $error("configuration write did not land");

  cfg_keep_a: assert property (!(reg_wr && cfg_hit) |=> $stable(cfg_r))
    else $error("configuration changed without a write");

  rvalid_rise_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");

  rvalid_pulse_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");

  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  unmapped_read_a: assert property (reg_rd && !cfg_hit && reg_addr != STAT_ADDR |=>
                                    reg_rdata == READ_UNMAPPED)
    else $error("unmapped read not zero");

  ten_off_a: assert property (!ten_mode |->
                              !port_ctrl.jabber_off && !port_ctrl.heartbeat_test
                              && !port_ctrl.twisted_pair_echo_off
                              && !port_ctrl.carrier_extend_select)
    else $error("10BASE-T controls active at 100 Mbps");

  scr_follow_a: assert property (port_state.speed100 |->
                                 port_ctrl.scr_bypass == cfg_r[CFG_SCR_BYPASS])
    else $error("scrambler bypass not following configuration");

  echo_follow_a: assert property (ten_mode && !port_state.full_duplex |->
                                  port_ctrl.twisted_pair_echo_off == cfg_r[CFG_ECHO_OFF])
    else $error("echo disable not following configuration");

  stat_more_a: assert property (
                                stat_word[STAT_SPEED100] == port_state.speed100
                                && stat_word[STAT_RX_ACT] == port_state.rx_active
                                && stat_word[STAT_AN_MODE] == port_state.an_enabled)
    else $error("status mode or activity mismatch");

  polarity_pass_a: assert property (ten_mode |->
                                    stat_word[STAT_POLARITY] == port_state.polarity_rev)
    else $error("polarity not reported at 10 Mbps");

  preamble_100_a: assert property (port_state.speed100 |-> port_ctrl.preamble_deliver)
    else $error("preamble not delivered at 100 Mbps");

  err_sticky_a: assert property (fault_s ##1 !fault_src_read [*2] |=> err_r)
    else $error("error flag did not stay set");

  link_release_a: assert property (!cfg_r[CFG_FORCE_LINK] |-> !port_ctrl.link_pass)
    else $error("link pass forced without the bit");

endmodule // phy_port_config_status_regs
`default_nettype wire

// ---- hw/phy_port_regs_pkg.sv ----
`default_nettype none
package phy_port_regs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned        ADDR_W          = 5;
  localparam int unsigned        DATA_W          = 16;
  localparam logic [ADDR_W-1:0]  CFG_ADDR        = 5'h10;
  localparam logic [ADDR_W-1:0]  STAT_ADDR       = 5'h11;
  localparam logic [DATA_W-1:0]  CFG_RESET       = 16'h0080;
  localparam logic [DATA_W-1:0]  STAT_RESET      = 16'h0000;
  localparam logic [DATA_W-1:0]  READ_UNMAPPED   = 16'h0000;

  // ****************************************************************
  // Configuration field positions
  // ****************************************************************
  localparam int unsigned CFG_FORCE_LINK   = 14;
  localparam int unsigned CFG_TX_DISABLE   = 13;
  localparam int unsigned CFG_SCR_BYPASS   = 12;
  localparam int unsigned CFG_JABBER_OFF   = 10;
  localparam int unsigned CFG_HEARTBEAT    = 9;
  localparam int unsigned CFG_ECHO_OFF     = 8;
  localparam int unsigned CFG_CRS_EXTEND   = 7;
  localparam int unsigned CFG_PRE_DELIVER  = 5;
  localparam int unsigned CFG_ALT_NP       = 1;

  // ****************************************************************
  // Status field positions
  // ****************************************************************
  localparam int unsigned STAT_SPEED100  = 14;
  localparam int unsigned STAT_TX_ACT    = 13;
  localparam int unsigned STAT_RX_ACT    = 12;
  localparam int unsigned STAT_COLL      = 11;
  localparam int unsigned STAT_LINK      = 10;
  localparam int unsigned STAT_DUPLEX    = 9;
  localparam int unsigned STAT_AN_MODE   = 8;
  localparam int unsigned STAT_AN_DONE   = 7;
  localparam int unsigned STAT_POLARITY  = 5;
  localparam int unsigned STAT_PAUSE     = 4;
  localparam int unsigned STAT_ERROR     = 3;

  // Live port state from the transceiver core
  typedef struct packed {
    logic speed100;
    logic tx_active;
    logic rx_active;
    logic collision;
    logic link_raw;
    logic full_duplex;
    logic an_enabled;
    logic an_complete;
    logic polarity_rev;
    logic pause_capable;
  } port_state_t;

  // Fault events that feed the summary error bit
  typedef struct packed {
    logic remote_fault;
    logic jabber;
    logic pd_fault;
  } fault_evt_t;

  // Controls handed to the datapath; the scrambler, 10BASE-T, echo and preamble ones already qualified by mode
  typedef struct packed {
    logic link_pass;
    logic tx_disable;
    logic scr_bypass;
    logic jabber_off;
    logic heartbeat_test;
    logic twisted_pair_echo_off;
    logic carrier_extend_select;
    logic preamble_deliver;
    logic alt_next_page_enable;
  } port_ctrl_t;

endpackage
`default_nettype wire

// ---- verif/station_mgr_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module station_mgr_model
  import phy_port_regs_pkg::*;
(
  input  wire logic              sys_clk,
  output var  logic [ADDR_W-1:0] reg_addr,
  output var  logic              reg_wr,
  output var  logic              reg_rd,
  output var  logic [DATA_W-1:0] reg_wdata
);
  // Reserved configuration bits 15, 11, 6, 4:3, 2 and 0
  localparam logic [DATA_W-1:0] RSVD_MASK = 16'h885D;

  initial begin
    reg_addr  = 5'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end

  // One strobe cycle; released lines show inverted junk, never the last value
  task automatic access(input logic [ADDR_W-1:0] a, input logic wr, input logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = (wr && a == CFG_ADDR) ? (d & ~RSVD_MASK) : d;
    reg_wr    = wr;
    reg_rd    = !wr;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~reg_wdata;
  endtask
endmodule // station_mgr_model
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import phy_port_regs_pkg::*;
;
  logic              sys_clk;
  logic              rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic              reg_rvalid;
  port_state_t       port_state;
  fault_evt_t        fault_evt;
  logic              fault_src_read;
  port_ctrl_t        port_ctrl;
  logic [DATA_W-1:0] cfg_m;
  logic [DATA_W-1:0] ctrl_m;
  logic              err_m;
  logic [DATA_W-1:0] exp_q[$];
  logic [31:0]       rnd;
  integer            seed = 40;
  int                bad_count = 0;
  int                samples_checked = 0;
  int                cyc = 0;

  phy_port_config_status_regs uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .port_state(port_state), .fault_evt(fault_evt),
    .fault_src_read(fault_src_read), .port_ctrl(port_ctrl));
  station_mgr_model mgr (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  // ****************************************************************
  // Checking
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] stat_exp(input port_state_t s);
    return {1'b0, s.speed100, s.tx_active, s.rx_active, s.collision, s.link_raw | cfg_m[14],
            s.full_duplex, s.an_enabled, s.an_complete, 1'b0, s.polarity_rev & !s.speed100,
            s.pause_capable, err_m, 3'b000};
  endfunction

  function automatic logic [15:0] ctrl_exp(input logic [15:0] c, input port_state_t s);
    logic t;
    t = !s.speed100;
    return {7'h00, c[14], c[13], c[12] & s.speed100, c[10] & t, c[9] & t,
            c[8] & t & !s.full_duplex, c[7] & t, c[5] | s.speed100, c[1]};
  endfunction

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    mgr.access(a, 1'b0, 16'h0000);
  endtask

  task automatic pulse_fault(input fault_evt_t f, input logic clr);
    @(negedge sys_clk);
    fault_evt      = f;
    fault_src_read = clr;
    @(negedge sys_clk);
    fault_evt      = 3'b000;
    fault_src_read = 1'b0;
  endtask

  // Read data is matched against the oldest pending note
  always @(negedge sys_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("queued reads", 16'h0001, 16'(exp_q.size()));
      end else begin
        chk("reg_rdata", exp_q.pop_front(), reg_rdata);
      end
    end
  end

  // ****************************************************************
  // Clock, timeout and stimulus
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    rst_n          = 1'b0;
    port_state     = '0;
    fault_evt      = 3'b000;
    fault_src_read = 1'b0;
    cfg_m          = 16'h0080;
    err_m          = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(CFG_ADDR, 16'h0080);
    rd(STAT_ADDR, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      rnd        = $random(seed);
      port_state = rnd[9:0];
      mgr.access(CFG_ADDR, 1'b1, rnd[31:16]);
      cfg_m = rnd[31:16] & ~16'h885D;
      ctrl_m = ctrl_exp(cfg_m, port_state);
      chk("port_ctrl", ctrl_m, 16'(port_ctrl));
      rd(CFG_ADDR, cfg_m);
      rd(STAT_ADDR, stat_exp(port_state));
    end
    mgr.access(STAT_ADDR, 1'b1, 16'hFFFF);
    mgr.access(5'h12, 1'b1, 16'hFFFF);
    rd(STAT_ADDR, stat_exp(port_state));
    rd(5'h12, 16'h0000);
    rd(CFG_ADDR, cfg_m);
    for (int f = 0; f < 3; f++) begin
      pulse_fault(fault_evt_t'(3'b001 << f), 1'b0);
      err_m = 1'b1;
      rd(STAT_ADDR, stat_exp(port_state));
      rd(STAT_ADDR, stat_exp(port_state));
      pulse_fault(3'b000, 1'b1);
      err_m = 1'b0;
      rd(STAT_ADDR, stat_exp(port_state));
    end
    // A clear that meets a fresh fault loses
    pulse_fault(3'b010, 1'b1);
    err_m = 1'b1;
    rd(STAT_ADDR, stat_exp(port_state));
    // Reset again in mid-run with the error flag and configuration dirty
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n  = 1'b1;
    cfg_m  = CFG_RESET;
    err_m  = 1'b0;
    ctrl_m = ctrl_exp(cfg_m, port_state);
    chk("port_ctrl", ctrl_m, 16'(port_ctrl));
    rd(CFG_ADDR, CFG_RESET);
    rd(STAT_ADDR, stat_exp(port_state));
    repeat (4) @(negedge sys_clk);
    chk("pending reads", 16'h0000, 16'(exp_q.size()));
    test_done();
  end
endmodule // tb_top
`default_nettype wire
